/* hw/adc_converter_end.sv */
// Function
// - host clock idles low, samples rising, at most 4MHz (50MHz over 14, about 3.57MHz)
// - host tx and rx clocks share sclk
// - shifting only while chip select low
// - control word 1xxxxx11 starts normal conversion
// - strobe falling edge marks result ready
// - sixteen rising edges carry result, trailers
// - chip select high disables until next
// - first one on input is start bit
// - power field picks state between conversions
// - shutdown pin low aborts conversion immediately
`timescale 1ns/10ps
module adc_converter_end (
	// clock and reset
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	// serial link
	adc_link_if.converter                             link,
	// user side
	input  wire logic [adc_link_pkg::CODE_BITS-1:0]   conv_value,
	output logic      [adc_link_pkg::CFG_MSB-adc_link_pkg::CFG_LSB:0] config_bits,
	output adc_link_pkg::power_mode_t                 power_mode_field,
	output logic                                      full_power,
	output logic                                      hw_powered_down,
	output logic                                      sample_taken
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CTRL = 2'b01,
		ST_CONV = 2'b11,
		ST_READ = 2'b10
	} conv_state_t;

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [1:0] sclk_sync_reg;
	logic [1:0] cs_sync_reg;
	logic [1:0] din_sync_reg;
	logic [1:0] shutdown_pin_n_sync_reg;
	logic       sclk_prev_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_sync_reg <= 2'h0;
			cs_sync_reg   <= 2'h3;
			din_sync_reg  <= 2'h0;
			shutdown_pin_n_sync_reg <= 2'h3;
			sclk_prev_reg <= 1'b0;
		end
		else
		begin
			sclk_sync_reg <= {sclk_sync_reg[0], link.sclk};
			cs_sync_reg   <= {cs_sync_reg[0], link.cs_n};
			din_sync_reg  <= {din_sync_reg[0], link.din};
			shutdown_pin_n_sync_reg <= {shutdown_pin_n_sync_reg[0], link.shutdown_pin_n};
			sclk_prev_reg <= sclk_sync_reg[1];
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic selected;
	logic shut_down;
	logic din_s;

	assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
	assign sclk_fall = ~sclk_sync_reg[1] & sclk_prev_reg;
	assign selected  = ~cs_sync_reg[1];
	assign shut_down = ~shutdown_pin_n_sync_reg[1];
	assign din_s     = din_sync_reg[1];

	// ****************************************
	// conversion sequencer
	// ****************************************
	conv_state_t                                state_reg;
	conv_state_t                                state_next;
	logic [adc_link_pkg::CTRL_BITS-1:0]         ctrl_reg;
	logic [adc_link_pkg::CTRL_BITS-1:0]         ctrl_next;
	logic [3:0]                                 count_reg;
	logic [3:0]                                 count_next;
	logic [adc_link_pkg::READ_BITS-1:0]         shift_reg;
	logic [adc_link_pkg::READ_BITS-1:0]         shift_next;
	logic                                       strobe_reg;
	logic                                       strobe_next;
	logic                                       full_reg;
	logic                                       full_next;
	adc_link_pkg::power_mode_t                  pwr_reg;
	adc_link_pkg::power_mode_t                  pwr_next;
	logic [adc_link_pkg::CFG_MSB-adc_link_pkg::CFG_LSB:0] cfg_reg;
	logic [adc_link_pkg::CFG_MSB-adc_link_pkg::CFG_LSB:0] cfg_next;
	logic                                       taken_reg;
	logic                                       taken_next;

	always_comb
	begin
		state_next  = state_reg;
		ctrl_next   = ctrl_reg;
		count_next  = count_reg;
		shift_next  = shift_reg;
		strobe_next = strobe_reg;
		full_next   = full_reg;
		pwr_next    = pwr_reg;
		cfg_next    = cfg_reg;
		taken_next  = 1'b0;
		if (shut_down)
		begin
			// hard power-down drops the conversion at once
			state_next  = ST_IDLE;
			strobe_next = 1'b0;
			full_next   = 1'b0;
			count_next  = 4'h0;
		end
		else if (!selected)
		begin
			// deselected: nothing is shifted in or out
			state_next  = ST_IDLE;
			strobe_next = 1'b0;
			count_next  = 4'h0;
			if (state_reg != ST_IDLE)
			begin
				full_next = 1'b0;
			end
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					// leading zeros are skipped until a one arrives
					if (sclk_rise && din_s)
					begin
						ctrl_next  = {{(adc_link_pkg::CTRL_BITS-1){1'b0}}, 1'b1};
						count_next = 4'h1;
						full_next  = 1'b1;
						state_next = ST_CTRL;
					end
				end
				ST_CTRL:
				begin
					if (sclk_rise)
					begin
						ctrl_next  = {ctrl_reg[adc_link_pkg::CTRL_BITS-2:0], din_s};
						count_next = count_reg + 4'h1;
						if (count_reg == adc_link_pkg::CTRL_LAST)
						begin
							// field 11 gives normal mode between conversions
							pwr_next    = adc_link_pkg::power_mode_t'(din_s ? {ctrl_reg[0], 1'b1}
							                                               : {ctrl_reg[0], 1'b0});
							cfg_next    = ctrl_reg[adc_link_pkg::CFG_MSB-1:adc_link_pkg::CFG_LSB-1];
							strobe_next = 1'b1;
							count_next  = 4'h0;
							state_next  = ST_CONV;
						end
					end
				end
				ST_CONV:
				begin
					count_next = count_reg + 4'h1;
					if (count_reg == adc_link_pkg::CONV_LAST)
					begin
						// 10-bit code, two fill bits, four trailers
						shift_next  = {conv_value, 2'h0, 4'h0};
						strobe_next = 1'b0;
						taken_next  = 1'b1;
						count_next  = 4'h0;
						state_next  = ST_READ;
					end
				end
				ST_READ:
				begin
					if (sclk_fall && count_reg != adc_link_pkg::READ_LAST)
					begin
						shift_next = {shift_reg[adc_link_pkg::READ_BITS-2:0], 1'b0};
						count_next = count_reg + 4'h1;
					end
					else if (sclk_fall)
					begin
						// frame over: leave full power until the next start
						full_next = 1'b0;
					end
				end
				default:
				begin
					state_next = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg  <= ST_IDLE;
			ctrl_reg   <= '0;
			count_reg  <= 4'h0;
			shift_reg  <= '0;
			strobe_reg <= 1'b0;
			full_reg   <= 1'b0;
			pwr_reg    <= adc_link_pkg::PWR_RESET;
			cfg_reg    <= '0;
			taken_reg  <= 1'b0;
		end
		else
		begin
			state_reg  <= state_next;
			ctrl_reg   <= ctrl_next;
			count_reg  <= count_next;
			shift_reg  <= shift_next;
			strobe_reg <= strobe_next;
			full_reg   <= full_next;
			pwr_reg    <= pwr_next;
			cfg_reg    <= cfg_next;
			taken_reg  <= taken_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign link.dout_drv              = shift_reg[adc_link_pkg::READ_BITS-1];
	assign link.dout_oe               = selected && (state_reg == ST_READ);
	assign link.conversion_strobe_out = strobe_reg;
	assign config_bits                = cfg_reg;
	assign power_mode_field           = pwr_reg;
	assign full_power                 = full_reg;
	assign hw_powered_down            = shut_down;
	assign sample_taken               = taken_reg;

endmodule : adc_converter_end

/* hw/adc_host_end.sv */
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
module adc_host_end (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial link
	adc_link_if.host         link
);

	typedef enum logic [2:0] {
		H_IDLE    = 3'b000,
		H_SEND    = 3'b001,
		H_WAIT_HI = 3'b011,
		H_WAIT_LO = 3'b010,
		H_RECV    = 3'b110,
		H_FINISH  = 3'b111
	} host_state_t;

	// ****************************************
	// return pin synchronisers
	// ****************************************
	logic [1:0] dout_sync_reg;
	logic [1:0] strobe_sync_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dout_sync_reg   <= 2'h0;
			strobe_sync_reg <= 2'h0;
		end
		else
		begin
			dout_sync_reg   <= {dout_sync_reg[0], link.dout};
			strobe_sync_reg <= {strobe_sync_reg[0], link.conversion_strobe_out};
		end
	end

	// ****************************************
	// apb decode
	// ****************************************
	logic wr_cmd;
	logic wr_config;
	logic wr_status;

	assign wr_cmd    = psel && penable && pwrite && (paddr == adc_link_pkg::CMD_ADDR);
	assign wr_config = psel && penable && pwrite && (paddr == adc_link_pkg::CONFIG_ADDR);
	assign wr_status = psel && penable && pwrite && (paddr == adc_link_pkg::STATUS_ADDR);
	assign pready    = 1'b1;
	assign pslverr   = 1'b0;

	// ****************************************
	// serial master
	// ****************************************
	host_state_t                             state_reg;
	host_state_t                             state_next;
	logic [3:0]                              div_reg;
	logic [3:0]                              div_next;
	logic [3:0]                              bit_reg;
	logic [3:0]                              bit_next;
	logic [adc_link_pkg::CTRL_BITS-1:0]      tx_reg;
	logic [adc_link_pkg::CTRL_BITS-1:0]      tx_next;
	logic [adc_link_pkg::READ_BITS-1:0]      rx_reg;
	logic [adc_link_pkg::READ_BITS-1:0]      rx_next;
	logic [adc_link_pkg::RESULT_BITS-1:0]    result_reg;
	logic [adc_link_pkg::RESULT_BITS-1:0]    result_next;
	logic                                    host_tx_clock_reg;
	logic                                    host_tx_clock_next;
	logic                                    cs_n_reg;
	logic                                    cs_n_next;
	logic                                    done_reg;
	logic                                    done_next;
	logic                                    run_reg;
	logic                                    run_next;
	logic                                    half_end;
	logic                                    host_rx_clock;

	assign half_end      = (div_reg == adc_link_pkg::HALF_LAST);
	assign host_rx_clock = host_tx_clock_reg;

	always_comb
	begin
		state_next         = state_reg;
		div_next           = half_end ? 4'h0 : div_reg + 4'h1;
		bit_next           = bit_reg;
		tx_next            = tx_reg;
		rx_next            = rx_reg;
		result_next        = result_reg;
		host_tx_clock_next = host_tx_clock_reg;
		cs_n_next          = cs_n_reg;
		done_next          = done_reg;
		run_next           = wr_config ? pwdata[adc_link_pkg::RUN_POS] : run_reg;
		if (wr_status && pwdata[adc_link_pkg::DONE_POS])
		begin
			done_next = 1'b0;
		end
		case (state_reg)
			H_IDLE:
			begin
				div_next = 4'h0;
				if (wr_cmd)
				begin
					tx_next    = pwdata[adc_link_pkg::CTRL_BITS-1:0];
					cs_n_next  = 1'b0;
					bit_next   = 4'h0;
					state_next = H_SEND;
				end
			end
			H_SEND:
			begin
				if (half_end)
				begin
					host_tx_clock_next = ~host_tx_clock_reg;
					if (host_tx_clock_reg)
					begin
						tx_next  = {tx_reg[adc_link_pkg::CTRL_BITS-2:0], 1'b0};
						bit_next = bit_reg + 4'h1;
						if (bit_reg == adc_link_pkg::CTRL_LAST)
						begin
							state_next = H_WAIT_HI;
						end
					end
				end
			end
			H_WAIT_HI:
			begin
				div_next = 4'h0;
				if (strobe_sync_reg[1])
				begin
					state_next = H_WAIT_LO;
				end
			end
			H_WAIT_LO:
			begin
				div_next = 4'h0;
				bit_next = 4'h0;
				if (!strobe_sync_reg[1])
				begin
					state_next = H_RECV;
				end
			end
			H_RECV:
			begin
				if (half_end)
				begin
					host_tx_clock_next = ~host_tx_clock_reg;
					if (!host_tx_clock_reg)
					begin
						// capture as the clock rises
						rx_next = {rx_reg[adc_link_pkg::READ_BITS-2:0], dout_sync_reg[1]};
					end
					else
					begin
						bit_next = bit_reg + 4'h1;
						if (bit_reg == adc_link_pkg::READ_LAST)
						begin
							// keep the top twelve, drop four trailers
							result_next = rx_reg[adc_link_pkg::READ_BITS-1:
							                     adc_link_pkg::READ_BITS-adc_link_pkg::RESULT_BITS];
							state_next  = H_FINISH;
						end
					end
				end
			end
			H_FINISH:
			begin
				if (half_end)
				begin
					// deselect a full half period after the last fall
					cs_n_next  = 1'b1;
					done_next  = 1'b1;
					state_next = H_IDLE;
				end
			end
			default:
			begin
				state_next = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg         <= H_IDLE;
			div_reg           <= 4'h0;
			bit_reg           <= 4'h0;
			tx_reg            <= '0;
			rx_reg            <= '0;
			result_reg        <= '0;
			host_tx_clock_reg <= 1'b0;
			cs_n_reg          <= 1'b1;
			done_reg          <= 1'b0;
			run_reg           <= adc_link_pkg::RUN_RESET;
		end
		else
		begin
			state_reg         <= state_next;
			div_reg           <= div_next;
			bit_reg           <= bit_next;
			tx_reg            <= tx_next;
			rx_reg            <= rx_next;
			result_reg        <= result_next;
			host_tx_clock_reg <= host_tx_clock_next;
			cs_n_reg          <= cs_n_next;
			done_reg          <= done_next;
			run_reg           <= run_next;
		end
	end

	// ****************************************
	// read mux and pins
	// ****************************************
	always_comb
	begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite)
		begin
			case (paddr)
				adc_link_pkg::CMD_ADDR:    prdata = {24'h00_0000, tx_reg};
				adc_link_pkg::CONFIG_ADDR: prdata = {31'h0000_0000, run_reg};
				adc_link_pkg::STATUS_ADDR: prdata = {30'h0000_0000, done_reg, state_reg != H_IDLE};
				adc_link_pkg::RESULT_ADDR: prdata = {20'h0_0000, result_reg};
				default:                   prdata = 32'h0000_0000;
			endcase
		end
	end

	assign link.sclk           = host_rx_clock;
	assign link.cs_n           = cs_n_reg;
	assign link.din            = (state_reg == H_SEND) ? tx_reg[adc_link_pkg::CTRL_BITS-1] : 1'b0;
	assign link.shutdown_pin_n = run_reg;

endmodule : adc_host_end

/* hw/adc_link_if.sv */
`timescale 1ns/10ps
interface adc_link_if;
	logic sclk;
	logic cs_n;
	logic din;
	logic dout_drv;
	logic dout_oe;
	logic conversion_strobe_out;
	logic shutdown_pin_n;
	logic dout;

	// undriven data line reads low
	assign dout = dout_oe & dout_drv;

	modport converter (
		input  sclk,
		input  cs_n,
		input  din,
		output dout_drv,
		output dout_oe,
		output conversion_strobe_out,
		input  shutdown_pin_n
	);

	modport host (
		output sclk,
		output cs_n,
		output din,
		input  dout,
		input  conversion_strobe_out,
		output shutdown_pin_n
	);
endinterface : adc_link_if

/* hw/adc_link_pkg.sv */
package adc_link_pkg;

	// ****************************************
	// link timing
	// ****************************************
	localparam int unsigned PCLK_HZ          = 50_000_000;
	localparam int unsigned SCLK_MAX_HZ      = 4_000_000;
	localparam int unsigned SCLK_HALF_CYCLES = (PCLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
	localparam logic [3:0]  HALF_LAST        = 4'(SCLK_HALF_CYCLES - 1);
	localparam logic [3:0]  CONV_LAST        = 4'h9;

	// ****************************************
	// frame layout
	// ****************************************
	localparam int unsigned CTRL_BITS    = 8;
	localparam int unsigned READ_BITS    = 16;
	localparam int unsigned CODE_BITS    = 10;
	localparam int unsigned RESULT_BITS  = 12;
	localparam logic [3:0]  CTRL_LAST    = 4'h7;
	localparam logic [3:0]  READ_LAST    = 4'hF;
	localparam int unsigned START_POS    = 7;
	localparam int unsigned CFG_LSB      = 2;
	localparam int unsigned CFG_MSB      = 6;
	localparam int unsigned PWR_LSB      = 0;
	localparam int unsigned PWR_MSB      = 1;

	typedef enum logic [1:0] {
		DEEP_SLEEP_MODE    = 2'h0,
		QUICK_SLEEP_MODE   = 2'h1,
		LOW_POWER_IDLE_MODE = 2'h2,
		NORMAL_MODE        = 2'h3
	} power_mode_t;

	localparam power_mode_t PWR_RESET = NORMAL_MODE;

	// ****************************************
	// host registers (apb byte addresses)
	// ****************************************
	localparam logic [7:0]  CMD_ADDR     = 8'h00;
	localparam logic [7:0]  CONFIG_ADDR  = 8'h04;
	localparam logic [7:0]  STATUS_ADDR  = 8'h08;
	localparam logic [7:0]  RESULT_ADDR  = 8'h0C;
	localparam int unsigned BUSY_POS     = 0;
	localparam int unsigned DONE_POS     = 1;
	localparam int unsigned RUN_POS      = 0;
	localparam logic        RUN_RESET    = 1'b1;

endpackage : adc_link_pkg

/* sim/adc_link_properties.sv */
`timescale 1ns/10ps
module adc_link_properties (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic conversion_strobe_out,
	input wire logic shutdown_pin_n
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ****************************************
	// link timing and framing
	// ****************************************
	idle_clock_low_a: assert property (cs_n |-> !sclk)
		else $error("serial clock high while deselected");
	clock_half_period_a: assert property ($rose(sclk) |-> sclk[*7])
		else $error("serial clock high phase too short");
	din_stable_high_a: assert property (sclk |-> $stable(din))
		else $error("host data changed while clock high");
	cs_edge_clock_low_a: assert property ($changed(cs_n) |-> !sclk && !$past(sclk))
		else $error("chip select moved near a clock pulse");
	strobe_selected_a: assert property ($rose(conversion_strobe_out) |-> !cs_n && shutdown_pin_n)
		else $error("strobe rose outside a selected frame");
	strobe_length_a: assert property ($fell(conversion_strobe_out) && shutdown_pin_n
		|-> $past(conversion_strobe_out, 10) && !$past(conversion_strobe_out, 11))
		else $error("strobe high time not ten cycles");
	readout_drive_a: assert property ($fell(conversion_strobe_out) && shutdown_pin_n
		|-> ##[0:1] dout_oe)
		else $error("data line not driven after strobe fall");
	dout_stable_high_a: assert property (sclk |-> $stable(dout))
		else $error("result bit changed while clock high");
	deselect_release_a: assert property (cs_n[*4] |-> !dout_oe && !conversion_strobe_out)
		else $error("converter active while deselected");
	shutdown_abort_a: assert property (!shutdown_pin_n[*4] |-> !conversion_strobe_out && !dout_oe)
		else $error("conversion kept running in shutdown");
endmodule : adc_link_properties

/* sim/tb.sv */
`timescale 1ns/10ps
module tb;
	logic                      pclk;
	logic                      presetn;
	logic                      psel;
	logic                      penable;
	logic                      pwrite;
	logic [7:0]                paddr;
	logic [31:0]               pwdata;
	logic [31:0]               prdata;
	logic                      pready;
	logic                      pslverr;
	logic [9:0]                conv_value;
	logic [4:0]                config_bits;
	adc_link_pkg::power_mode_t power_mode_field;
	logic                      full_power;
	logic                      hw_powered_down;
	logic                      sample_taken;
	logic                      saw_fp;
	int                        mismatches;
	int                        checked;
	int                        takes;

	adc_link_if link();

	adc_host_end u_adc_host_end (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link.host));

	adc_converter_end u_adc_converter_end (.pclk(pclk), .presetn(presetn), .link(link.converter),
		.conv_value(conv_value), .config_bits(config_bits), .power_mode_field(power_mode_field),
		.full_power(full_power), .hw_powered_down(hw_powered_down), .sample_taken(sample_taken));

	adc_link_properties u_adc_link_properties (.pclk(pclk), .presetn(presetn), .sclk(link.sclk),
		.cs_n(link.cs_n), .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe),
		.conversion_strobe_out(link.conversion_strobe_out), .shutdown_pin_n(link.shutdown_pin_n));

	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// ****************************************
	// monitors
	// ****************************************
	always @(posedge pclk)
	begin
		if (sample_taken === 1'b1)
			takes <= takes + 1;
		if (full_power === 1'b1)
			saw_fp <= 1'b1;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wait_idle;
		logic [31:0] q;
		int          n;
		q = 32'h1;
		n = 0;
		while (q[0] !== 1'b0 && n < 1000)
		begin
			apb(1'b0, adc_link_pkg::STATUS_ADDR, 32'h0, q);
			n++;
		end
		check(q & 32'h3, 32'h2);
	endtask : wait_idle

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		logic [31:0] q;
		apb(1'b0, adc_link_pkg::CONFIG_ADDR, 32'h0, q);
		check(q, 32'h1);
		apb(1'b0, adc_link_pkg::STATUS_ADDR, 32'h0, q);
		check(q, 32'h0);
		check(32'(link.cs_n), 32'h1);
		check(32'(power_mode_field), 32'h3);
		check({full_power, hw_powered_down}, 32'h0);
	endtask : t_reset

	task automatic t_conv(input logic [7:0] ctrl, input logic [9:0] code);
		logic [31:0] q;
		int          t0;
		conv_value <= code;
		saw_fp = 1'b0;
		t0 = takes;
		apb(1'b1, adc_link_pkg::CMD_ADDR, {24'h0, ctrl}, q);
		wait_idle();
		apb(1'b0, adc_link_pkg::RESULT_ADDR, 32'h0, q);
		check(q, {20'h0, code, 2'b00});
		check(32'(config_bits), 32'(ctrl[6:2]));
		check(32'(power_mode_field), 32'(ctrl[1:0]));
		check(takes - t0, 1);
		check({saw_fp, full_power}, 32'h2);
		apb(1'b1, adc_link_pkg::STATUS_ADDR, 32'h2, q);
		apb(1'b0, adc_link_pkg::STATUS_ADDR, 32'h0, q);
		check(q, 32'h0);
	endtask : t_conv

	task automatic t_busy_refuse;
		logic [31:0] q;
		conv_value <= 10'h0F0;
		apb(1'b1, adc_link_pkg::CMD_ADDR, 32'h83, q);
		apb(1'b0, adc_link_pkg::STATUS_ADDR, 32'h0, q);
		check(q & 32'h1, 32'h1);
		apb(1'b1, adc_link_pkg::CMD_ADDR, 32'hFC, q);
		wait_idle();
		check(32'(config_bits), 32'h0);
		check(32'(power_mode_field), 32'h3);
		apb(1'b0, adc_link_pkg::RESULT_ADDR, 32'h0, q);
		check(q, 32'h3C0);
		apb(1'b1, adc_link_pkg::STATUS_ADDR, 32'h2, q);
	endtask : t_busy_refuse

	task automatic t_unmapped;
		logic [31:0] q;
		apb(1'b1, 8'h10, 32'hFFFFFFFF, q);
		apb(1'b0, 8'h10, 32'h0, q);
		check(q, 32'h0);
		check(32'(pslverr), 32'h0);
		check(32'(pready), 32'h1);
		apb(1'b0, adc_link_pkg::CONFIG_ADDR, 32'h0, q);
		check(q, 32'h1);
	endtask : t_unmapped

	task automatic t_shutdown;
		logic [31:0] q;
		int          n;
		conv_value <= 10'h1A5;
		apb(1'b1, adc_link_pkg::CMD_ADDR, 32'h83, q);
		n = 0;
		while (link.conversion_strobe_out !== 1'b1 && n < 400)
		begin
			@(posedge pclk);
			n++;
		end
		check(32'(link.conversion_strobe_out), 32'h1);
		apb(1'b1, adc_link_pkg::CONFIG_ADDR, 32'h0, q);
		repeat (6) @(posedge pclk);
		check({hw_powered_down, link.conversion_strobe_out, link.dout_oe, full_power}, 32'h8);
		apb(1'b1, adc_link_pkg::CONFIG_ADDR, 32'h1, q);
		repeat (6) @(posedge pclk);
		check(32'(hw_powered_down), 32'h0);
		// aborted frame: host still finishes, undriven line reads low
		wait_idle();
		apb(1'b0, adc_link_pkg::RESULT_ADDR, 32'h0, q);
		check(q, 32'h0);
	endtask : t_shutdown

	task report_and_stop;
		$display("mismatches=%0d checked=%0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		presetn    = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 8'h00;
		pwdata     = 32'h0;
		conv_value = 10'h000;
		saw_fp     = 1'b0;
		mismatches = 0;
		checked    = 0;
		takes      = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_conv(8'h83, 10'h3FF);
		t_conv(8'hFC, 10'h000);
		t_conv(8'hA9, 10'h2AA);
		t_conv(8'hD6, 10'h155);
		t_busy_refuse();
		t_unmapped();
		t_shutdown();
		report_and_stop();
	end

	initial
	begin
		repeat (30000) @(posedge pclk);
		mismatches++;
		report_and_stop();
	end
endmodule : tb
